// *** core/cmfc_pkg.sv ***
// package for the cpu mode register and fetch control block
// assumes a 32-bit cpu store/load port into the control area
package cmfc_pkg;
    localparam logic [31:0] CMFC_ADDR_MAIN = 32'hff2f0000;
    localparam logic [31:0] CMFC_ADDR_MIRROR = 32'h1f2f0000;
    localparam int CMFC_RSD_BIT = 5;
    // reserved-bit initial value is not printed; neutral choice
    localparam logic [31:0] CMFC_RESET_VAL = 32'h00000000;
    localparam logic [31:0] CMFC_WRITE_MASK = 32'h00000020;
    localparam logic [31:0] CMFC_AREA_TAIL = 32'h00000040;
    localparam logic [31:0] CMFC_AREA_SIZE = 32'h04000000;
    localparam logic [3:0] CMFC_PF_WORDS = 4'h8;
    typedef enum logic [1:0] {SYNC_IDLE, SYNC_WRITTEN, SYNC_READ}
        cmfc_sync_t;
endpackage

// *** core/cmfc_prefetch.sv ***
// instruction prefetch request generator
// assumes a simple req/ack external fetch bus on the same clock
`timescale 1ns/100ps
module cmfc_prefetch import cmfc_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // fetch control
    input wire logic start_i,
    input wire logic [31:0] start_addr_i,
    // external bus
    output logic req_o,
    output logic [31:0] addr_o,
    input wire logic ack_i
);
    typedef struct packed {
        logic req;
        logic [31:0] addr;
        logic [3:0] left;
    } cmfc_pf_t;
    cmfc_pf_t st, next_st;
    always_comb begin
        next_st = st;
        if (st.req) begin
            // no ack, no retire: the request is held forever
            if (ack_i) begin
                next_st.addr = st.addr + 32'h00000004;
                next_st.left = st.left - 4'h1;
                next_st.req = (st.left != 4'h1);
            end
        end else if (start_i) begin
            // prefetch runs on regardless of area ends
            next_st.req = 1'b1;
            next_st.addr = start_addr_i;
            next_st.left = CMFC_PF_WORDS;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign req_o = st.req;
    assign addr_o = st.addr;
endmodule // cmfc_prefetch

// *** core/cmfc_top.sv ***
// cpu operation mode register with fetch control
// assumes cpu store/load requests on clk_i, big-endian word addresses
// assumes pipeline event pulses and the fetch bus share clk_i, so no
// input needs a synchroniser
`timescale 1ns/100ps
module cmfc_top import cmfc_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // cpu register port
    input wire logic cpu_wr_i,
    input wire logic cpu_rd_i,
    input wire logic [31:0] cpu_addr_i,
    input wire logic [31:0] cpu_wdata_i,
    output logic [31:0] cpu_rdata_o,
    output logic cpu_hit_o,
    // pipeline events
    input wire logic sync_insn_i,
    input wire logic sub_return_i,
    input wire logic [31:0] return_addr_i,
    input wire logic seq_fetch_i,
    input wire logic [31:0] seq_addr_i,
    // status
    output logic return_spec_en_o,
    output logic mode_pending_o,
    // external fetch bus
    output logic fetch_req_o,
    output logic [31:0] fetch_addr_o,
    input wire logic fetch_ack_i
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        // setting as last written by software
        logic [31:0] mode;
        // setting that steers the fetch logic
        logic [31:0] active;
        cmfc_sync_t sync;
        // read data and match flag, one cycle after the access
        logic [31:0] rdata;
        logic hit;
    } cmfc_state_t;
    cmfc_state_t st;
    cmfc_state_t next_st;

    // decode results
    logic any_access;
    logic main_match;
    logic mirror_match;
    logic sel;
    logic rd_hit;
    logic wr_hit;

    // write and read images of the mode register
    logic [31:0] wr_image;
    logic [31:0] rd_image;

    // activation handshake events
    logic take_read;
    logic take_sync;

    // fetch steering
    logic active_rsd;
    logic spec_take;
    logic pf_start;
    logic [31:0] pf_addr;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    // exact word match only: a byte or halfword offset inside the
    // register word misses, as partial accesses are not supported
    always_comb begin
        main_match = 1'b0;
        mirror_match = 1'b0;
        if (cpu_addr_i == CMFC_ADDR_MAIN) begin
            main_match = 1'b1;
        end else if (cpu_addr_i == CMFC_ADDR_MIRROR) begin
            mirror_match = 1'b1;
        end
    end
    assign any_access = cpu_rd_i | cpu_wr_i;
    assign sel = main_match | mirror_match;
    assign rd_hit = sel & cpu_rd_i;
    assign wr_hit = sel & cpu_wr_i;

    // ----------------------------------------
    // write image
    // ----------------------------------------
    // reserved bits never take the written value, so a careless write
    // cannot leave them off their initial value
    for (genvar b = 0; b < 32; b++) begin : g_image
        if (CMFC_WRITE_MASK[b]) begin : g_rw
            assign wr_image[b] = cpu_wdata_i[b];
        end else begin : g_rsv
            assign wr_image[b] = CMFC_RESET_VAL[b];
        end
    end

    // ----------------------------------------
    // readback image
    // ----------------------------------------
    // reserved bits read their initial value whatever the storage
    // holds, so read-modify-write sequences keep them intact
    for (genvar r = 0; r < 32; r++) begin : g_read
        if (CMFC_WRITE_MASK[r]) begin : g_rw
            assign rd_image[r] = st.mode[r];
        end else begin : g_rsv
            assign rd_image[r] = CMFC_RESET_VAL[r];
        end
    end

    // ----------------------------------------
    // activation handshake
    // ----------------------------------------
    // a readback only counts once a write is waiting for it
    assign take_read = rd_hit && (st.sync == SYNC_WRITTEN);
    // a sync before the readback is ignored, keeping the old setting
    assign take_sync = sync_insn_i && (st.sync == SYNC_READ);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.hit = sel & any_access;
        next_st.rdata = 32'h00000000;
        if (rd_hit) begin
            next_st.rdata = rd_image;
        end
        case (st.sync)
            SYNC_IDLE: begin
                // nothing to do until a store lands
                next_st.sync = SYNC_IDLE;
            end
            SYNC_WRITTEN: begin
                if (take_read) begin
                    next_st.sync = SYNC_READ;
                end
            end
            SYNC_READ: begin
                if (take_sync) begin
                    next_st.active = st.mode;
                    next_st.sync = SYNC_IDLE;
                end
            end
            default: begin
                next_st.sync = SYNC_IDLE;
            end
        endcase
        // a new write restarts the handshake; a sync in the same cycle still activates the old setting
        if (wr_hit) begin
            next_st.mode = wr_image;
            next_st.sync = SYNC_WRITTEN;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // reset restores the initial setting, so speculation starts enabled
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st.mode <= CMFC_RESET_VAL;
            st.active <= CMFC_RESET_VAL;
            st.sync <= SYNC_IDLE;
            st.rdata <= 32'h00000000;
            st.hit <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // fetch steering
    // ----------------------------------------
    assign active_rsd = st.active[CMFC_RSD_BIT];
    assign return_spec_en_o = ~active_rsd;
    // speculative return fetch outranks a sequential start
    assign spec_take = sub_return_i & return_spec_en_o;
    always_comb begin
        pf_start = 1'b0;
        pf_addr = seq_addr_i;
        if (spec_take) begin
            pf_start = 1'b1;
            pf_addr = return_addr_i;
        end else if (seq_fetch_i) begin
            pf_start = 1'b1;
            pf_addr = seq_addr_i;
        end
    end

    // ----------------------------------------
    // prefetch requester
    // ----------------------------------------
    // a burst with no answer never retires, so an empty area hangs
    // the fetch bus; starts that arrive meanwhile are dropped
    cmfc_prefetch u_pf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(pf_start),
        .start_addr_i(pf_addr),
        .req_o(fetch_req_o),
        .addr_o(fetch_addr_o),
        .ack_i(fetch_ack_i)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign cpu_rdata_o = st.rdata;
    assign cpu_hit_o = st.hit;
    always_comb begin
        if (st.sync == SYNC_IDLE) begin
            mode_pending_o = 1'b0;
        end else begin
            mode_pending_o = 1'b1;
        end
    end
endmodule // cmfc_top

// *** verif/cmfc_sva.sv ***
// checker for the mode register and fetch ports of cmfc_top
// assumes one clock domain; bound at the foot of this file
`timescale 1ns/100ps
module cmfc_sva import cmfc_pkg::*; (
    // cpu port
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cpu_wr_i,
    input wire logic cpu_rd_i,
    input wire logic sync_insn_i,
    input wire logic [31:0] cpu_addr_i,
    input wire logic [31:0] cpu_rdata_o,
    input wire logic cpu_hit_o,
    input wire logic mode_pending_o,
    input wire logic return_spec_en_o,
    // fetch side
    input wire logic sub_return_i,
    input wire logic seq_fetch_i,
    input wire logic [31:0] return_addr_i,
    input wire logic fetch_req_o,
    input wire logic [31:0] fetch_addr_o,
    input wire logic fetch_ack_i
);
    // ------
    // checks
    // ------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire ok = cpu_addr_i == CMFC_ADDR_MAIN || cpu_addr_i == CMFC_ADDR_MIRROR;
    sequence s_beat;
        fetch_req_o && fetch_ack_i ##1 fetch_req_o;
    endsequence
    hit_map_a:
    assert property ((cpu_wr_i || cpu_rd_i) && ok |=> cpu_hit_o)
        else $error("no hit");
    miss_zero_a:
    assert property (cpu_rd_i && !ok |=> !cpu_hit_o && cpu_rdata_o == 32'h0)
        else $error("miss gave data");
    rsv_read_a:
    assert property ((cpu_rdata_o & ~CMFC_WRITE_MASK) == 32'h0)
        else $error("rsv");
    mode_hold_a:
    assert property ($changed(return_spec_en_o) |->
        $past(sync_insn_i) && $past(mode_pending_o)) else $error("early mode");
    spec_go_a:
    assert property (sub_return_i && !fetch_req_o && !seq_fetch_i |=>
        fetch_req_o == $past(return_spec_en_o)) else $error("spec fetch");
    req_hold_a:
    assert property (fetch_req_o && !fetch_ack_i |=>
        fetch_req_o && $stable(fetch_addr_o)) else $error("req dropped");
    addr_step_a:
    assert property (s_beat |-> fetch_addr_o == $past(fetch_addr_o) + 32'h4)
        else $error("bad step");
endmodule // cmfc_sva
bind cmfc_top cmfc_sva cmfc_sva_i (.*);

// *** verif/cmfc_tb_top.sv ***
// bench: drives cmfc_top and compares it with an integer model
// assumes cmfc_pkg and the bound checker are compiled first
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("mismatch %0t %h %h", $time, a, b); end end
module cmfc_tb_top import cmfc_pkg::*;;
    // ---------------
    // model and tests
    // ---------------
    logic clk_i = 1'h0, rst_i = 1'h1, cpu_wr_i = 1'h0, cpu_rd_i = 1'h0;
    logic sync_insn_i = 1'h0, sub_return_i = 1'h0, seq_fetch_i = 1'h0;
    logic fetch_ack_i = 1'h0, cpu_hit_o, return_spec_en_o, mode_pending_o;
    logic fetch_req_o;
    logic [31:0] cpu_addr_i = 32'h0, cpu_wdata_i = 32'h0;
    logic [31:0] return_addr_i = 32'h0;
    logic [31:0] seq_addr_i = 32'h0, cpu_rdata_o, fetch_addr_o, q[$];
    logic [15:0] rnd = 16'h0046;
    int n_mismatch = 0, cmp_count = 0, cyc = 0, st = 0, b5 = 0, act = 1;
    cmfc_top cmfc_top_i (.*);
    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) if (++cyc > 1000) begin
        n_mismatch++;
        print_verdict();
    end
    function automatic logic [15:0] lfsr(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic print_verdict;
        $display("counts %0d %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // k is {store, load, sync}; the model steps on the same edge
    task automatic op(input logic [2:0] k, input logic [31:0] a, d);
        int hit;
        @(negedge clk_i);
        {cpu_wr_i, cpu_rd_i, sync_insn_i, cpu_addr_i, cpu_wdata_i} = {k, a, d};
        @(negedge clk_i);
        {cpu_wr_i, cpu_rd_i, sync_insn_i} = 3'h0;
        hit = k[2:1] != 0 && (a == CMFC_ADDR_MAIN || a == CMFC_ADDR_MIRROR);
        if (k[0] && st == 2) begin
            st = 0;
            act = !b5;
        end
        if (hit && k[2]) begin
            st = 1;
            b5 = d[5];
        end
        if (hit && k[1] && st == 1) st = 2;
        `CHK(cpu_hit_o, 1'(hit))
        `CHK(cpu_rdata_o, hit && k[1] ? 32'(b5) << 5 : 32'h0)
        `CHK(mode_pending_o, 1'(st != 0))
        `CHK(return_spec_en_o, 1'(act))
    endtask
    // random ack gaps make the requester hold its address while stalled
    task automatic fetch(input logic sr, input logic [31:0] a);
        @(negedge clk_i);
        {seq_fetch_i, sub_return_i, seq_addr_i, return_addr_i} = {~sr, sr, a, a};
        @(negedge clk_i);
        {seq_fetch_i, sub_return_i} = 2'h0;
        for (int i = 0; i < 8 && (act || !sr); i++) q.push_back(a + 32'(4 * i));
        `CHK(fetch_req_o, 1'(q.size() > 0))
        while (q.size() > 0) begin
            rnd = lfsr(rnd);
            repeat (rnd[1:0]) @(negedge clk_i);
            `CHK(fetch_addr_o, q.pop_front())
            fetch_ack_i = 1'h1;
            @(negedge clk_i);
            fetch_ack_i = 1'h0;
        end
        `CHK(fetch_req_o, 1'h0)
    endtask
    initial begin
        repeat (6) @(negedge clk_i);
        rst_i = 1'h0;
        op(3'h2, CMFC_ADDR_MAIN, 32'h0);
        op(3'h4, CMFC_ADDR_MIRROR, 32'h20);
        op(3'h1, 32'h0, 32'h0);
        op(3'h2, CMFC_ADDR_MAIN + 32'h2, 32'h0);
        repeat (40) begin
            rnd = lfsr(rnd);
            op(3'h1 << rnd[1:0], rnd[2] ? CMFC_ADDR_MAIN : rnd[3] ?
                CMFC_ADDR_MIRROR : {rnd, rnd}, {rnd, rnd} & CMFC_WRITE_MASK);
        end
        $display("test registers done");
        for (int k = 0; k < 2; k++) begin
            op(3'h4, CMFC_ADDR_MAIN, 32'(k) << 5);
            op(3'h2, CMFC_ADDR_MAIN, 32'h0);
            op(3'h1, 32'h0, 32'h0);
            fetch(1'h1, 32'h100);
            fetch(1'h0, 32'h200);
        end
        $display("test fetch done");
        print_verdict();
    end
endmodule // cmfc_tb_top
